// >>> hw/tss_reg_map.vh
`ifndef TSS_REG_MAP_VH
`define TSS_REG_MAP_VH
// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define TSS_ADDR_W        16
`define TSS_OFS_RATIO_A   16'h2014
`define TSS_OFS_RATIO_B   16'h2024
`define TSS_OFS_RATIO_C   16'h2034
`define TSS_OFS_CS_BASE   16'h2040
`define TSS_OFS_Q_BASE    16'h2050
`define TSS_OFS_Q_WP      16'h2052
`define TSS_OFS_Q_RP      16'h2054
`define TSS_OFS_CTRL      16'h2060
`define TSS_OFS_STATUS    16'h2062
`define TSS_OFS_MASK      16'h2064
// ---------------------------------------------------------------
// field layouts
// ---------------------------------------------------------------
`define TSS_RATIO_RNG     2:0
`define TSS_SINGLE_BIT    3
`define TSS_INIT_RNG      7:6
`define TSS_CSB_RNG       4:0
`define TSS_QBASE_RNG     11:0
`define TSS_QSIZE_RNG     13:12
`define TSS_WP_RNG        7:0
`define TSS_RP_RNG        6:0
`define TSS_CTRL_QEN_BIT  0
`define TSS_CTRL_SEN_RNG  3:1
`define TSS_ST_OVR_BIT    0
`define TSS_ST_CELL_BIT   1
// ---------------------------------------------------------------
// constants
// ---------------------------------------------------------------
`define TSS_ZERO16        16'h0000
`define TSS_FRAMES_MULTI  3'h4
`define TSS_FRAMES_ONE    3'h1
`define TSS_SZ16          2'h0
`define TSS_SZ32          2'h1
`define TSS_SZ64          2'h2
`define TSS_MASK16        7'h0f
`define TSS_MASK32        7'h1f
`define TSS_MASK64        7'h3f
`define TSS_MASK128       7'h7f
`define TSS_ONE7          7'h01
`define TSS_INIT_A        2'h1
`define TSS_INIT_B        2'h2
`define TSS_INIT_C        2'h3
`endif

// >>> hw/tss_tx_seg_regs.v
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
`include "tss_reg_map.vh"
//
// Contract
// - long turns per short turn follow the 3-bit ratio field.
// - assembly bit one builds one frame at a time, zero four frames.
// - control structure address: base as bits 20:16, entry bits 15:4.
// - queue entry address: base bits 20:9, 64-byte cell buffers.
// - size field 00/01/10/11 gives 16/32/64/128 cells.
// - write pointer slot is being filled and not yet valid.
// - read-only pointer reports slot being sent, still valid.
// - reserved upper bits of base and pointer registers read zero.
// - host write of write pointer equal read pointer sets overrun.
module tss_tx_seg_regs (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire [15:0] reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    output reg         irq,
    input  wire [1:0]  cs_sched_sel,
    input  wire [11:0] cs_entry,
    output reg  [20:0] cs_addr,
    output reg  [2:0]  sched_a_ratio,
    output reg  [2:0]  sched_b_ratio,
    output reg  [2:0]  sched_c_ratio,
    output reg  [2:0]  frames_per_build,
    output reg  [2:0]  sched_enable,
    output reg  [2:0]  sched_init_seen,
    output reg         cell_avail,
    output reg  [20:0] cell_addr,
    input  wire        cell_done
);

// ---------------------------------------------------------------
// functions
// ---------------------------------------------------------------
function [6:0] size_mask;
    input [1:0] sz;
    begin
        case (sz)
            `TSS_SZ16: size_mask = `TSS_MASK16;
            `TSS_SZ32: size_mask = `TSS_MASK32;
            `TSS_SZ64: size_mask = `TSS_MASK64;
            default:   size_mask = `TSS_MASK128;
        endcase
    end
endfunction

function hit;
    input [15:0] a;
    input [15:0] ofs;
    begin
        hit = (a == ofs);
    end
endfunction

function init_match;
    input [15:0] wdata;
    input [1:0]  code;
    begin
        init_match = (wdata[`TSS_INIT_RNG] == code);
    end
endfunction

// set wins over write-one-to-clear
function sticky_next;
    input cur;
    input set;
    input clr;
    begin
        sticky_next = set || (cur && !clr);
    end
endfunction

// ---------------------------------------------------------------
// registers
// ---------------------------------------------------------------
reg  [3:0]  ratio_a_ff;
reg  [3:0]  ratio_b_ff;
reg  [3:0]  ratio_c_ff;
reg         init_a_ff;
reg         init_b_ff;
reg         init_c_ff;
reg  [4:0]  cs_base_ff;
reg  [13:0] q_base_ff;
reg  [7:0]  wp_ff;
reg  [6:0]  rp_ff;
reg  [3:0]  ctrl_ff;
reg  [1:0]  status_ff;
reg  [1:0]  mask_ff;

wire [6:0]  qmask    = size_mask(q_base_ff[`TSS_QSIZE_RNG]);
wire [6:0]  wp_slot  = wp_ff[6:0] & qmask;
wire [6:0]  rp_slot  = rp_ff & qmask;
wire        q_en     = ctrl_ff[`TSS_CTRL_QEN_BIT];
wire        q_ready  = q_en && (rp_slot != wp_slot);
wire        wr_ratio_a = reg_wr && hit(reg_addr, `TSS_OFS_RATIO_A);
wire        wr_ratio_b = reg_wr && hit(reg_addr, `TSS_OFS_RATIO_B);
wire        wr_ratio_c = reg_wr && hit(reg_addr, `TSS_OFS_RATIO_C);
wire        wr_wp      = reg_wr && hit(reg_addr, `TSS_OFS_Q_WP);
wire        wr_st      = reg_wr && hit(reg_addr, `TSS_OFS_STATUS);
wire        wr_cs_base = reg_wr && hit(reg_addr, `TSS_OFS_CS_BASE);
wire        wr_q_base  = reg_wr && hit(reg_addr, `TSS_OFS_Q_BASE);
wire        wr_ctrl    = reg_wr && hit(reg_addr, `TSS_OFS_CTRL);
wire        wr_mask    = reg_wr && hit(reg_addr, `TSS_OFS_MASK);
wire        advance    = cell_done && q_ready;
wire [6:0]  rp_inc     = (rp_ff + `TSS_ONE7) & qmask;
wire [6:0]  slot_now   = advance ? rp_inc : rp_slot;
wire        clr_ovr    = wr_st && reg_wdata[`TSS_ST_OVR_BIT];
wire        clr_cell   = wr_st && reg_wdata[`TSS_ST_CELL_BIT];

// overrun: written pointer lands on the read pointer
wire ovr_evt  = wr_wp && (reg_wdata[6:0] & qmask) == rp_slot;
wire cell_evt = advance;

// ---------------------------------------------------------------
// scheduler ratio registers
// ---------------------------------------------------------------
// bits 5:4 are not stored; init code is write-only
always @(posedge clk) begin
    if (sys_rst) begin
        ratio_a_ff <= 4'h0;
        init_a_ff  <= 1'b0;
    end else if (wr_ratio_a) begin
        ratio_a_ff <= reg_wdata[3:0];
        init_a_ff  <= init_match(reg_wdata, `TSS_INIT_A);
    end
end

always @(posedge clk) begin
    if (sys_rst) begin
        ratio_b_ff <= 4'h0;
        init_b_ff  <= 1'b0;
    end else if (wr_ratio_b) begin
        ratio_b_ff <= reg_wdata[3:0];
        init_b_ff  <= init_match(reg_wdata, `TSS_INIT_B);
    end
end

always @(posedge clk) begin
    if (sys_rst) begin
        ratio_c_ff <= 4'h0;
        init_c_ff  <= 1'b0;
    end else if (wr_ratio_c) begin
        ratio_c_ff <= reg_wdata[3:0];
        init_c_ff  <= init_match(reg_wdata, `TSS_INIT_C);
    end
end

// ---------------------------------------------------------------
// base, pointer and control registers
// ---------------------------------------------------------------
always @(posedge clk) begin
    if (sys_rst)
        cs_base_ff <= 5'h00;
    else if (wr_cs_base)
        cs_base_ff <= reg_wdata[`TSS_CSB_RNG];
end

always @(posedge clk) begin
    if (sys_rst)
        q_base_ff <= 14'h0000;
    else if (wr_q_base)
        q_base_ff <= reg_wdata[13:0];
end

always @(posedge clk) begin
    if (sys_rst)
        wp_ff <= 8'h00;
    else if (wr_wp)
        wp_ff <= reg_wdata[`TSS_WP_RNG];
end

always @(posedge clk) begin
    if (sys_rst)
        ctrl_ff <= 4'h0;
    else if (wr_ctrl)
        ctrl_ff <= reg_wdata[3:0];
end

always @(posedge clk) begin
    if (sys_rst)
        mask_ff <= 2'h0;
    else if (wr_mask)
        mask_ff <= reg_wdata[1:0];
end

// ---------------------------------------------------------------
// read pointer
// ---------------------------------------------------------------
always @(posedge clk) begin
    if (sys_rst)
        rp_ff <= 7'h00;
    else if (advance)
        rp_ff <= rp_inc;
end

// ---------------------------------------------------------------
// sticky status
// ---------------------------------------------------------------
always @(posedge clk) begin
    if (sys_rst) begin
        status_ff <= 2'h0;
    end else begin
        status_ff[`TSS_ST_OVR_BIT]  <= sticky_next(
            status_ff[`TSS_ST_OVR_BIT], ovr_evt, clr_ovr);
        status_ff[`TSS_ST_CELL_BIT] <= sticky_next(
            status_ff[`TSS_ST_CELL_BIT], cell_evt, clr_cell);
    end
end

// ---------------------------------------------------------------
// read side
// ---------------------------------------------------------------
reg [15:0] nxt_rdata;
always @* begin
    nxt_rdata = `TSS_ZERO16;
    case (reg_addr)
        `TSS_OFS_RATIO_A: nxt_rdata = {12'h000, ratio_a_ff};
        `TSS_OFS_RATIO_B: nxt_rdata = {12'h000, ratio_b_ff};
        `TSS_OFS_RATIO_C: nxt_rdata = {12'h000, ratio_c_ff};
        `TSS_OFS_CS_BASE: nxt_rdata = {11'h000, cs_base_ff};
        `TSS_OFS_Q_BASE:  nxt_rdata = {2'h0, q_base_ff};
        `TSS_OFS_Q_WP:    nxt_rdata = {8'h00, wp_ff};
        `TSS_OFS_Q_RP:    nxt_rdata = {9'h000, rp_ff};
        `TSS_OFS_CTRL:    nxt_rdata = {12'h000, ctrl_ff};
        `TSS_OFS_STATUS:  nxt_rdata = {14'h0000, status_ff};
        `TSS_OFS_MASK:    nxt_rdata = {14'h0000, mask_ff};
        default:          nxt_rdata = `TSS_ZERO16;
    endcase
end

// ---------------------------------------------------------------
// ratio select for frames_per_build
// ---------------------------------------------------------------
reg [4:0] sel_ratio;
always @* begin
    case (cs_sched_sel)
        2'h0:    sel_ratio = {1'b0, ratio_a_ff};
        2'h1:    sel_ratio = {1'b0, ratio_b_ff};
        default: sel_ratio = {1'b0, ratio_c_ff};
    endcase
end

// ---------------------------------------------------------------
// bus-facing outputs
// ---------------------------------------------------------------
always @(posedge clk) begin
    if (sys_rst) begin
        reg_rdata <= `TSS_ZERO16;
        irq       <= 1'b0;
    end else begin
        reg_rdata <= reg_rd ? nxt_rdata : `TSS_ZERO16;
        irq       <= |(status_ff & mask_ff);
    end
end

// ---------------------------------------------------------------
// scheduler-facing outputs
// ---------------------------------------------------------------
always @(posedge clk) begin
    if (sys_rst) begin
        cs_addr          <= 21'h000000;
        sched_a_ratio    <= 3'h0;
        sched_b_ratio    <= 3'h0;
        sched_c_ratio    <= 3'h0;
        frames_per_build <= `TSS_FRAMES_MULTI;
        sched_enable     <= 3'h0;
        sched_init_seen  <= 3'h0;
    end else begin
        cs_addr          <= {cs_base_ff, cs_entry, 4'h0};
        sched_a_ratio    <= ratio_a_ff[`TSS_RATIO_RNG];
        sched_b_ratio    <= ratio_b_ff[`TSS_RATIO_RNG];
        sched_c_ratio    <= ratio_c_ff[`TSS_RATIO_RNG];
        frames_per_build <= sel_ratio[`TSS_SINGLE_BIT] ?
            `TSS_FRAMES_ONE : `TSS_FRAMES_MULTI;
        sched_enable     <= ctrl_ff[`TSS_CTRL_SEN_RNG];
        sched_init_seen  <= {init_c_ff, init_b_ff, init_a_ff};
    end
end

// ---------------------------------------------------------------
// queue-facing outputs
// ---------------------------------------------------------------
always @(posedge clk) begin
    if (sys_rst) begin
        cell_avail <= 1'b0;
        cell_addr  <= 21'h000000;
    end else begin
        cell_avail <= q_ready && !advance;
        // 64-byte buffers: slot shifts in at bit 6
        cell_addr  <= {q_base_ff[`TSS_QBASE_RNG], 9'h000} +
                      {8'h00, slot_now, 6'h00};
    end
end

endmodule

// >>> dv/tss_tx_seg_regs_assertions.sv
`timescale 1ns/1ns
module tss_regs_chk (
    input logic        clk,
    input logic        sys_rst,
    input logic [15:0] reg_addr,
    input logic [15:0] reg_wdata,
    input logic        reg_wr,
    input logic        reg_rd,
    input logic [15:0] reg_rdata,
    input logic        irq,
    input logic [11:0] cs_entry,
    input logic [20:0] cs_addr,
    input logic [2:0]  sched_a_ratio,
    input logic [2:0]  sched_init_seen,
    input logic        cell_avail,
    input logic [20:0] cell_addr,
    input logic        cell_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_idle; !reg_rd |=> reg_rdata == 16'h0; endproperty
    a_idle: assert property (p_idle) else $error("rdata not idle");
    property p_rp; reg_rd && reg_addr == 16'h2054 |=> !(|reg_rdata[15:7]);
    endproperty
    a_rp: assert property (p_rp) else $error("rp upper bits");
    property p_cs; 1'b1 |=> cs_addr[15:0] == {$past(cs_entry), 4'h0};
    endproperty
    a_cs: assert property (p_cs) else $error("cs addr low");
    property p_lo; cell_addr[5:0] == 6'h0; endproperty
    a_lo: assert property (p_lo) else $error("cell addr align");
    property p_rat; reg_wr && reg_addr == 16'h2014
        |-> ##2 sched_a_ratio == $past(reg_wdata[2:0], 2); endproperty
    a_rat: assert property (p_rat) else $error("ratio a");
    property p_ini; reg_wr && reg_addr == 16'h2014
        |-> ##2 sched_init_seen[0] == ($past(reg_wdata[7:6], 2) == 2'h1);
    endproperty
    a_ini: assert property (p_ini) else $error("init a");
    property p_adv; cell_avail && cell_done |=> $changed(cell_addr);
    endproperty
    a_adv: assert property (p_adv) else $error("no advance");
    property p_irq; $rose(irq) |-> $past(reg_wr, 2) || $past(cell_done, 2);
    endproperty
    a_irq: assert property (p_irq) else $error("irq cause");
    c_adv: cover property (cell_avail && cell_done);
    c_irq: cover property (irq);
    c_rd: cover property (reg_rd && reg_addr == 16'h2054);
endmodule
bind tss_tx_seg_regs tss_regs_chk u_chk (.*);

// >>> dv/tss_engine_model.sv
`timescale 1ns/1ns
module tss_engine_model (
    input  logic clk,
    input  logic sys_rst,
    input  logic cell_avail,
    input  logic slow,
    output logic cell_done
);
    logic [2:0] wait_ff;
    always @(posedge clk) begin
        cell_done <= 1'b0;
        if (sys_rst || !cell_avail || cell_done)
            wait_ff <= slow ? 3'h5 : 3'h0;
        else if (wait_ff != 3'h0)
            wait_ff <= wait_ff - 3'h1;
        else
            cell_done <= 1'b1;
    end
endmodule

// >>> dv/tss_tx_seg_regs_test.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
 miscompares++; $display("Error %0t mismatch", $time); end end
module tss_tx_seg_regs_test;
    logic        clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, slow = 0;
    logic [15:0] reg_addr = 16'h0, reg_wdata = 16'h0, reg_rdata, d;
    logic [1:0]  cs_sched_sel = 2'h0;
    logic [11:0] cs_entry = 12'h0, b;
    logic [20:0] cs_addr, cell_addr;
    logic [2:0]  sched_a_ratio, sched_b_ratio, sched_c_ratio;
    logic [2:0]  frames_per_build, sched_enable, sched_init_seen;
    logic        irq, cell_avail, cell_done;
    logic [31:0] rnd = 32'heb8aa3fa;
    logic [15:0] adr [5] = '{16'h2040, 16'h2050, 16'h2052, 16'h2054, 16'h2070};
    int          miscompares = 0, checks_done = 0, cyc = 0, n;
    wire  [8:0]  rat = {sched_c_ratio, sched_b_ratio, sched_a_ratio};
    tss_tx_seg_regs dut (.*);
    tss_engine_model u_eng (.clk, .sys_rst, .cell_avail, .slow, .cell_done);
    initial forever #2 clk = ~clk;
    always @(posedge clk) if (++cyc == 40000) begin
        miscompares++;
        finish_test;
    end
    function logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function logic [20:0] ecell(input logic [11:0] bb, input int s);
        return {bb, 9'h0} + 21'(s * 64);
    endfunction
    task finish_test;
        if (miscompares == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task rst;
        sys_rst <= 1'b1;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
    endtask
    task wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [15:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task drain(input int t);
        d = 16'hffff;
        for (int i = 0; i < 1000 && d != 16'(t); i++) begin
            rnd = nx(rnd);
            slow <= rnd[0];
            rd(16'h2054);
        end
        `CHK(d, 16'(t))
    endtask
    initial begin
        rst;
        foreach (adr[i]) begin
            rd(adr[i]);
            `CHK(d, 16'h0)
        end
        wr(16'h2040, 16'hffff);
        rd(16'h2040);
        `CHK(d, 16'h001f)
        cs_entry <= rnd[11:0];
        repeat (2) @(posedge clk);
        #1 `CHK(cs_addr, {5'h1f, cs_entry, 4'h0})
        for (int i = 0; i < 12; i++) begin
            rnd = nx(rnd);
            d = {8'h0, rnd[1] ? 2'(i / 4 + 1) : 2'h0, 2'h0, rnd[0],
                 3'((1 << (i % 4)) - 1)};
            wr(16'h2014 + 16'(i / 4 * 16), d);
            cs_sched_sel <= 2'(i / 4);
            rd(16'h2014 + 16'(i / 4 * 16));
            `CHK(d, {12'h0, reg_wdata[3:0]})
            `CHK(rat[3 * (i / 4) +: 3], reg_wdata[2:0])
            `CHK(frames_per_build, reg_wdata[3] ? 3'h1 : 3'h4)
            `CHK(sched_init_seen[i / 4], reg_wdata[7:6] != 2'h0)
        end
        for (int s = 0; s < 4; s++) begin
            n = 16 << s;
            rst;
            rnd = nx(rnd);
            b = {rnd[11:4], 4'h0};
            wr(16'h2050, {2'h0, 2'(s), b});
            wr(16'h2064, 16'h0001);
            wr(16'h2060, 16'h000f);
            wr(16'h2052, 16'(n - 1));
            drain(n - 1);
            `CHK(cell_avail, 1'b0)
            wr(16'h2052, 16'(n + 2));
            drain(2);
            `CHK(cell_addr, ecell(b, 2))
            wr(16'h2052, 16'h0002);
            repeat (2) @(posedge clk);
            #1 `CHK(irq, 1'b1)
            wr(16'h2062, 16'h0001);
            repeat (2) @(posedge clk);
            #1 `CHK(irq, 1'b0)
            `CHK(sched_enable, 3'h7)
        end
        finish_test;
    end
endmodule
